// File: rtl/dpr_abort_unit.v
/*
 * Abort decoder: turns a write to the abort register into a one-cycle
 * abort pulse and one-cycle clear pulses for the four sticky flags.
 * Assumes the write strobe is a one-cycle pulse on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.vh"

module dpr_abort_unit
(
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // decoded abort write
    input  wire        abort_wr,
    input  wire [31:0] wdata,
    // pulses
    output reg         abort_pulse_ff,
    output reg         clr_orun_ff,
    output reg         clr_wde_ff,
    output reg         clr_err_ff,
    output reg         clr_cmp_ff
);

    // bits 31:5 are ignored; the debugger writes them as zero
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            abort_pulse_ff <= 1'b0;
            clr_orun_ff    <= 1'b0;
            clr_wde_ff     <= 1'b0;
            clr_err_ff     <= 1'b0;
            clr_cmp_ff     <= 1'b0;
        end
        else
        begin
            abort_pulse_ff <= abort_wr & wdata[`DPR_AB_REQ];
            clr_orun_ff    <= abort_wr & wdata[`DPR_AB_ORUN_CLR];
            clr_wde_ff     <= abort_wr & wdata[`DPR_AB_WDE_CLR];
            clr_err_ff     <= abort_wr & wdata[`DPR_AB_ERR_CLR];
            clr_cmp_ff     <= abort_wr & wdata[`DPR_AB_CMP_CLR];
        end
    end

endmodule // dpr_abort_unit
`default_nettype wire

// File: rtl/dpr_base_ptr.v
/*
 * Base pointer read values: builds the low and high pointer words from
 * the component address, its presence flag and the address width.
 * Assumes the strap inputs are static after reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.vh"

module dpr_base_ptr
(
    // configuration
    input  wire [63:0]              base_addr,
    input  wire                     base_valid,
    input  wire [`DPR_ADDRESS_WIDTH_FIELD_W-1:0]  addr_width,
    // read values
    output wire [31:0]              base_low,
    output wire [31:0]              base_high
);

    wire [63:0] mask;
    wire [63:0] masked;

    // keep only bits below the system address width
    genvar i;
    generate
        for (i = 0; i < 64; i = i + 1)
        begin : g_mask
            assign mask[i] = (i < addr_width);
        end
    endgenerate

    assign masked = base_addr & mask;
    // low word: address bits 31:12, 11:1 zero, valid in bit 0
    assign base_low  = {masked[`DPR_BP_MSB:`DPR_BP_LSB], 11'h000,
                        base_valid};
    assign base_high = masked[63:32];

endmodule // dpr_base_ptr
`default_nettype wire

// File: rtl/dpr_regmap.v
/*
 * Debug port register map: word decode with bank selection, abort
 * register, sticky flags, base pointers and the read buffer.
 * Assumes a link front end that presents one-cycle read and write strobes
 * with a word offset, all on ref_clk; error events come from the access
 * unit on the same clock.
 */
// Functional notes
// - addresses word aligned, low bits zero
// - bank field selects registers at 0x0, 0x4
// - write to 0x0 is abort or reserved
// - serial variant reaches abort at 0x0
// - abort discards all pending access transactions
// - abort leaves sticky flags unchanged
// - abort bit zero aborts, stops counter
// - unreachable access unit answers wait
// - abort bit four clears overrun flag
// - abort bit three clears write-data error
// - abort bit two clears transaction error
// - abort bit one clears compare flag
// - abort is 32-bit write only
// - uncancellable transaction may need system reset
// - high pointer bits 63:32, low 31:12
// - base 4KB aligned, bits 11:1 zero
// - low bit zero valid indicator
// - pointer bits above width read zero
// - 12-bit width: valid marks component presence
// - pointers read-only at 0x0 banks 2,3
// - reserved locations read zero
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.vh"

module dpr_regmap
(
    // clock and reset
    input  wire                     ref_clk,
    input  wire                     rst,
    // link front end register access
    input  wire                     reg_rd,
    input  wire                     reg_wr,
    input  wire [3:0]               reg_addr,
    input  wire [31:0]              reg_wdata,
    output reg  [31:0]              reg_rdata_ff,
    output reg                      reg_rvalid_ff,
    output reg                      reg_addr_err_ff,
    // link type: high when abort is register mapped at offset 0x0
    input  wire                     abort_mapped,
    // access unit side
    input  wire                     ap_busy,
    input  wire                     ap_cancellable,
    input  wire                     ap_rdata_vld,
    input  wire [31:0]              ap_rdata,
    input  wire                     ev_orun,
    input  wire                     ev_wde,
    input  wire                     ev_err,
    input  wire                     ev_cmp,
    input  wire                     ev_fault_out,
    input  wire                     ap_wait_clear,
    output reg                      ap_abort_ff,
    output reg                      ap_wait_ff,
    output reg                      ap_stuck_ff,
    output reg                      trn_stop_ff,
    // power and reset handshakes
    input  wire                     sys_pwr_ack,
    input  wire                     dbg_pwr_ack,
    input  wire                     dbg_rst_ack,
    output reg                      sys_pwr_req_ff,
    output reg                      dbg_pwr_req_ff,
    output reg                      dbg_rst_req_ff,
    // configuration straps
    input  wire [63:0]              base_addr,
    input  wire                     base_valid,
    input  wire [`DPR_ADDRESS_WIDTH_FIELD_W-1:0]  addr_width
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers for the acknowledge pins

    reg  [2:0] ack_s1_ff;
    reg  [2:0] ack_s2_ff;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_s1_ff <= 3'h0;
            ack_s2_ff <= 3'h0;
        end
        else
        begin
            ack_s1_ff <= {sys_pwr_ack, dbg_pwr_ack, dbg_rst_ack};
            ack_s2_ff <= ack_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire [`DPR_OFS_W-1:0] ofs;
    reg  [31:0]           select_ff;
    reg  [31:0]           link_ctl_ff;
    reg  [31:0]           read_result_buffer_ff;
    wire [`DPR_BANK_W-1:0] bank;
    wire                  wr_abort;
    wire                  wr_select;
    wire                  wr_ctrl;
    wire                  wr_link;

    // only the word offset is decoded; reg_addr[1:0] only feeds reg_addr_err_ff
    assign ofs  = reg_addr[3:2];
    assign bank = select_ff[`DPR_BANK_MSB:`DPR_BANK_LSB];

    // offset 0x0 write ignores the bank; reserved unless link maps abort
    assign wr_abort  = reg_wr & (ofs == `DPR_OFS_BANKED0) & abort_mapped;
    assign wr_select = reg_wr & (ofs == `DPR_OFS_SELECT);
    assign wr_ctrl   = reg_wr & (ofs == `DPR_OFS_BANKED4)
                       & (bank == `DPR_B4_CTRL_STAT);
    assign wr_link   = reg_wr & (ofs == `DPR_OFS_BANKED4)
                       & (bank == `DPR_B4_LINK_CTL);

    ////////////////////////////////////////////////////////////////////////
    // abort decode and base pointers

    wire abort_p;
    wire clr_orun;
    wire clr_wde;
    wire clr_err;
    wire clr_cmp;
    wire [31:0] base_low;
    wire [31:0] base_high;

    dpr_abort_unit u_abort
    (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .abort_wr       (wr_abort),
        .wdata          (reg_wdata),
        .abort_pulse_ff (abort_p),
        .clr_orun_ff    (clr_orun),
        .clr_wde_ff     (clr_wde),
        .clr_err_ff     (clr_err),
        .clr_cmp_ff     (clr_cmp)
    );

    dpr_base_ptr u_base
    (
        .base_addr  (base_addr),
        .base_valid (base_valid),
        .addr_width (addr_width),
        .base_low   (base_low),
        .base_high  (base_high)
    );

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: set wins over clear; an abort alone clears none

    reg orun_ff;
    reg wde_ff;
    reg err_ff;
    reg cmp_ff;
    reg orun_det_ff;
    reg errmode_ff;
    reg [`DPR_CS_CNT_W-1:0] trn_cnt_ff;
    reg [3:0] masklane_ff;
    reg [1:0] trnmode_ff;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            orun_ff <= 1'b0;
            wde_ff  <= 1'b0;
            err_ff  <= 1'b0;
            cmp_ff  <= 1'b0;
        end
        else
        begin
            orun_ff <= (ev_orun & orun_det_ff) | (orun_ff & ~clr_orun);
            wde_ff  <= ev_wde | (wde_ff & ~clr_wde);
            // with error mode set, a fault answer also clears the flag
            err_ff  <= ev_err | (err_ff & ~clr_err
                                 & ~(errmode_ff & ev_fault_out));
            cmp_ff  <= ev_cmp | (cmp_ff & ~clr_cmp);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control fields and transaction counter

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            orun_det_ff    <= 1'b0;
            errmode_ff     <= 1'b0;
            trn_cnt_ff     <= {`DPR_CS_CNT_W{1'b0}};
            masklane_ff    <= `DPR_ZERO4;
            trnmode_ff     <= 2'h0;
            sys_pwr_req_ff <= 1'b0;
            dbg_pwr_req_ff <= 1'b0;
            dbg_rst_req_ff <= 1'b0;
            trn_stop_ff    <= 1'b0;
        end
        else
        begin
            trn_stop_ff <= abort_p & (trn_cnt_ff != {`DPR_CS_CNT_W{1'b0}});
            if (wr_ctrl)
            begin
                orun_det_ff    <= reg_wdata[`DPR_CS_ORUN_DET];
                errmode_ff     <= reg_wdata[`DPR_CS_ERRMODE];
                masklane_ff    <= reg_wdata[11:8];
                trnmode_ff     <= reg_wdata[3:2];
                sys_pwr_req_ff <= reg_wdata[`DPR_CS_SYSPWR_REQ];
                dbg_pwr_req_ff <= reg_wdata[`DPR_CS_DBGPWR_REQ];
                dbg_rst_req_ff <= reg_wdata[`DPR_CS_DBGRST_REQ];
            end
            if (abort_p)
                trn_cnt_ff <= {`DPR_CS_CNT_W{1'b0}};
            else if (wr_ctrl)
                trn_cnt_ff <= reg_wdata[`DPR_CS_CNT_MSB:`DPR_CS_CNT_LSB];
            else if (ap_rdata_vld && trn_cnt_ff != {`DPR_CS_CNT_W{1'b0}})
                trn_cnt_ff <= trn_cnt_ff - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access unit abort, wait and stuck state

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ap_abort_ff <= 1'b0;
            ap_wait_ff  <= 1'b0;
            ap_stuck_ff <= 1'b0;
        end
        else
        begin
            // one pulse flushes every cancellable outstanding and queued transaction
            ap_abort_ff <= abort_p;
            // unreachable registers answer wait until the unit recovers
            if (abort_p)
                ap_wait_ff <= 1'b1;
            else if (ap_wait_clear & ~ap_stuck_ff)
                ap_wait_ff <= 1'b0;
            // an uncancellable transfer stays stuck until system reset
            if (abort_p & ap_busy & ~ap_cancellable)
                ap_stuck_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // select, link control and read buffer

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            select_ff   <= `DPR_ZERO32;
            link_ctl_ff <= `DPR_ZERO32;
            read_result_buffer_ff   <= `DPR_ZERO32;
        end
        else
        begin
            if (wr_select)
                select_ff <= reg_wdata;
            if (wr_link)
                link_ctl_ff <= reg_wdata;
            if (ap_rdata_vld)
                read_result_buffer_ff <= ap_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux

    wire [31:0] ctrl_stat;
    wire [31:0] ident_ext;
    reg  [31:0] nxt_rdata;

    assign ctrl_stat = {ack_s2_ff[2], sys_pwr_req_ff, ack_s2_ff[1], dbg_pwr_req_ff,
                        ack_s2_ff[0], dbg_rst_req_ff, 1'b0, errmode_ff,
                        trn_cnt_ff, masklane_ff, wde_ff, ~ap_wait_ff, err_ff,
                        cmp_ff, trnmode_ff, orun_ff, orun_det_ff};
    assign ident_ext = {25'h0000000, addr_width};

    always @*
    begin
        nxt_rdata = `DPR_ZERO32;
        case (ofs)
            `DPR_OFS_BANKED0:
            begin
                case (bank)
                    `DPR_B0_IDENT:     nxt_rdata = `DPR_IDENT_VAL;
                    `DPR_B0_IDENT_EXT: nxt_rdata = ident_ext;
                    `DPR_B0_BASE_LOW:  nxt_rdata = base_low;
                    `DPR_B0_BASE_HIGH: nxt_rdata = base_high;
                    default:           nxt_rdata = `DPR_ZERO32;
                endcase
            end
            `DPR_OFS_BANKED4:
            begin
                case (bank)
                    `DPR_B4_CTRL_STAT:  nxt_rdata = ctrl_stat;
                    `DPR_B4_LINK_CTL:   nxt_rdata = link_ctl_ff;
                    `DPR_B4_TARGET_ID:  nxt_rdata = `DPR_TARGET_VAL;
                    `DPR_B4_LINK_PID:   nxt_rdata = `DPR_LINK_PID_VAL;
                    `DPR_B4_EVENT_STAT: nxt_rdata = `DPR_ZERO32;
                    `DPR_B4_SEL_EXT:    nxt_rdata = `DPR_ZERO32;
                    default:            nxt_rdata = `DPR_ZERO32;
                endcase
            end
            // select is write only and reads as zero here
            `DPR_OFS_READ_RESULT_BUFFER: nxt_rdata = read_result_buffer_ff;
            default:         nxt_rdata = `DPR_ZERO32;
        endcase
    end

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata_ff    <= `DPR_ZERO32;
            reg_rvalid_ff   <= 1'b0;
            reg_addr_err_ff <= 1'b0;
        end
        else
        begin
            reg_rvalid_ff   <= reg_rd;
            reg_addr_err_ff <= (reg_rd | reg_wr) & (reg_addr[1:0] != 2'h0);
            if (reg_rd)
                reg_rdata_ff <= nxt_rdata;
        end
    end

endmodule // dpr_regmap
`default_nettype wire

// File: rtl/dpr_regs.vh
/*
 * Register offsets, bank codes, field positions and reset values for the
 * debug port register map. Included by every file of the block; holds
 * definitions only.
 */
`ifndef DPR_REGS_VH
`define DPR_REGS_VH

// word offsets (address bits [3:2]); nonzero bits [1:0] only set reg_addr_err_ff
`define DPR_OFS_W          2
`define DPR_OFS_BANKED0    2'h0
`define DPR_OFS_BANKED4    2'h1
`define DPR_OFS_SELECT     2'h2
`define DPR_OFS_READ_RESULT_BUFFER     2'h3

// bank field: bits [3:0] of the select register
`define DPR_BANK_W         4
`define DPR_BANK_LSB       0
`define DPR_BANK_MSB       3

// bank codes at offset 0x0
`define DPR_B0_IDENT       4'h0
`define DPR_B0_IDENT_EXT   4'h1
`define DPR_B0_BASE_LOW    4'h2
`define DPR_B0_BASE_HIGH   4'h3

// bank codes at offset 0x4
`define DPR_B4_CTRL_STAT   4'h0
`define DPR_B4_LINK_CTL    4'h1
`define DPR_B4_TARGET_ID   4'h2
`define DPR_B4_LINK_PID    4'h3
`define DPR_B4_EVENT_STAT  4'h4
`define DPR_B4_SEL_EXT     4'h5

// abort register fields
`define DPR_AB_REQ         0
`define DPR_AB_CMP_CLR     1
`define DPR_AB_ERR_CLR     2
`define DPR_AB_WDE_CLR     3
`define DPR_AB_ORUN_CLR    4

// control/status fields
`define DPR_CS_ORUN_DET    0
`define DPR_CS_ORUN        1
`define DPR_CS_CMP         4
`define DPR_CS_ERR         5
`define DPR_CS_READOK      6
`define DPR_CS_WDE         7
`define DPR_CS_ERRMODE     24
`define DPR_CS_CNT_LSB     12
`define DPR_CS_CNT_MSB     23
`define DPR_CS_CNT_W       12
`define DPR_CS_DBGRST_REQ  26
`define DPR_CS_DBGRST_ACK  27
`define DPR_CS_DBGPWR_REQ  28
`define DPR_CS_DBGPWR_ACK  29
`define DPR_CS_SYSPWR_REQ  30
`define DPR_CS_SYSPWR_ACK  31

// base pointer layout
`define DPR_BP_VALID       0
`define DPR_BP_LSB         12
`define DPR_BP_MSB         31
`define DPR_BP_W           20

// address width codes and width in bits
`define DPR_ADDRESS_WIDTH_FIELD_W        7
`define DPR_ADDRESS_WIDTH_FIELD_12       7'h0C
`define DPR_ADDRESS_WIDTH_FIELD_32       7'h20
`define DPR_ADDRESS_WIDTH_FIELD_64       7'h40

// arbitrary neutral identity values
`define DPR_IDENT_VAL      32'h0000_0001
`define DPR_TARGET_VAL     32'h0000_0001
`define DPR_LINK_PID_VAL   32'h0000_0001

`define DPR_ZERO32         32'h0000_0000
`define DPR_ZERO4          4'h0

`endif

// File: tb/dpr_ap_model.sv
/*
 * Access unit and power controller model on the far side.
 * Assumes abort arrives as a one-cycle pulse on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dpr_ap_model
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // scenario control
    input  wire logic go_busy,
    input  wire logic cancel_ok,
    // from the register map
    input  wire logic ap_abort,
    input  wire logic [2:0] pwr_req,
    // to the register map
    output var logic ap_busy,
    output wire logic ap_cancellable,
    output var logic [2:0] pwr_ack
);
    assign ap_cancellable = cancel_ok;
    // an uncancellable transfer stays in flight, as a real stall would
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ap_busy <= 1'b0;
        else if (go_busy)
            ap_busy <= 1'b1;
        else if (ap_abort && cancel_ok)
            ap_busy <= 1'b0;
    end
    // acks trail requests by one cycle
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pwr_ack <= 3'h0;
        else
            pwr_ack <= pwr_req;
    end
endmodule // dpr_ap_model
`default_nettype wire

// File: tb/dpr_regmap_props.sv
/*
 * Port-level checker for the debug port register map.
 * Assumes one clock, async high reset, one-cycle register strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module dpr_regmap_chk
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // register bus
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic        reg_addr_err_ff,
    // access unit side
    input wire logic        abort_mapped,
    input wire logic        ap_abort_ff,
    input wire logic        ap_wait_ff,
    input wire logic        ap_stuck_ff,
    input wire logic        trn_stop_ff,
    input wire logic        sys_pwr_req_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire abt_wr = reg_wr && (reg_addr[3:2] == 2'h0) && abort_mapped;
    wire cs_wr  = reg_wr && (reg_addr[3:2] == 2'h1);
    AST_ABORT_FROM_WR: assert property (
        abt_wr && reg_wdata[0] |-> ##2 ap_abort_ff) else $error("abort write lost");
    AST_ABORT_ONLY_WR: assert property (
        ap_abort_ff |-> $past(abt_wr && reg_wdata[0], 2)) else $error("stray abort");
    AST_WAIT_ON_ABORT: assert property (
        ap_abort_ff |-> ap_wait_ff) else $error("no wait after abort");
    AST_MISALIGNED: assert property (
        (reg_rd || reg_wr) && (reg_addr[1:0] != 2'h0) |=> reg_addr_err_ff)
        else $error("misaligned access not flagged");
    AST_STUCK_HOLDS: assert property (
        ap_stuck_ff |=> ap_stuck_ff) else $error("stuck flag dropped");
    AST_STOP_WITH_ABORT: assert property (
        trn_stop_ff |-> ap_abort_ff) else $error("counter stop without abort");
    AST_RDATA_HOLDS: assert property (
        !$past(reg_rd) |-> $stable(reg_rdata_ff)) else $error("read data moved");
    AST_PWR_REQ_SRC: assert property (
        $changed(sys_pwr_req_ff) |-> $past(cs_wr) || $past(cs_wr, 2))
        else $error("power request moved without write");
endmodule // dpr_regmap_chk

bind dpr_regmap dpr_regmap_chk u_chk
(
    .ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .reg_addr_err_ff(reg_addr_err_ff), .abort_mapped(abort_mapped),
    .ap_abort_ff(ap_abort_ff), .ap_wait_ff(ap_wait_ff), .ap_stuck_ff(ap_stuck_ff),
    .trn_stop_ff(trn_stop_ff), .sys_pwr_req_ff(sys_pwr_req_ff)
);
`default_nettype wire

// File: tb/tb.sv
/*
 * Self-checking bench for dpr_regmap.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.vh"
module tb;
    logic        ref_clk = 1'b0, rst = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, ap_rdata = 32'h0, reg_rdata_ff;
    logic [5:0]  evs = 6'h0;
    logic        abort_mapped = 1'b0, go_busy = 1'b0, cancel_ok = 1'b1;
    logic        base_valid = 1'b0;
    logic [63:0] base_addr = 64'h0;
    logic [6:0]  addr_width = 7'h0;
    logic        reg_rvalid_ff, reg_addr_err_ff, ap_abort_ff, ap_wait_ff;
    logic        ap_stuck_ff, trn_stop_ff, ap_busy, ap_cancellable;
    // nets: the request bits come from three separate design ports
    wire  [2:0]  req, ack;
    int          err_total = 0, n_compared = 0, n_ab = 0, n_st = 0, cyc = 0;

    dpr_regmap uut
    (
        .ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff), .reg_addr_err_ff(reg_addr_err_ff),
        .abort_mapped(abort_mapped), .ap_busy(ap_busy), .ap_cancellable(ap_cancellable),
        .ap_rdata_vld(evs[0]), .ap_rdata(ap_rdata), .ev_orun(evs[5]), .ev_wde(evs[4]),
        .ev_err(evs[3]), .ev_cmp(evs[2]), .ev_fault_out(1'b0), .ap_wait_clear(evs[1]),
        .ap_abort_ff(ap_abort_ff), .ap_wait_ff(ap_wait_ff), .ap_stuck_ff(ap_stuck_ff),
        .trn_stop_ff(trn_stop_ff), .sys_pwr_ack(ack[2]), .dbg_pwr_ack(ack[1]),
        .dbg_rst_ack(ack[0]), .sys_pwr_req_ff(req[2]), .dbg_pwr_req_ff(req[1]),
        .dbg_rst_req_ff(req[0]), .base_addr(base_addr), .base_valid(base_valid),
        .addr_width(addr_width)
    );
    dpr_ap_model u_ap
    (
        .ref_clk(ref_clk), .rst(rst), .go_busy(go_busy), .cancel_ok(cancel_ok),
        .ap_abort(ap_abort_ff), .pwr_req(req), .ap_busy(ap_busy),
        .ap_cancellable(ap_cancellable), .pwr_ack(ack)
    );

    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        n_ab += ap_abort_ff;
        n_st += trn_stop_ff;
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] m, e);
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, reg_rvalid_ff});
        chk(nm, e, reg_rdata_ff & m);
    endtask
    // one-cycle pulse on the event and access unit strobes
    task automatic evp(input logic [5:0] f);
        @(posedge ref_clk);
        #1;
        evs = f;
        @(posedge ref_clk);
        #1;
        evs = 6'h0;
    endtask
    task automatic strap(input logic [63:0] a, input logic vl, input logic [6:0] w);
        @(posedge ref_clk);
        #1;
        rst = 1'b1;
        base_addr = a;
        base_valid = vl;
        addr_width = w;
        repeat (4) @(posedge ref_clk);
        #1;
        rst = 1'b0;
    endtask
    task automatic ptrs(input logic [31:0] lo, input logic [31:0] hi);
        wr(4'h8, 32'h2);
        rc("base_low", 4'h0, '1, lo);
        wr(4'h8, 32'h3);
        rc("base_high", 4'h0, '1, hi);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_map();
        logic [31:0] e0 [4];
        e0 = '{`DPR_IDENT_VAL, 32'h40, 32'h5678_9001, 32'h0000_1234};
        strap(64'h0000_1234_5678_9ABC, 1'b1, 7'h40);
        for (int i = 0; i < 16; i++)
        begin
            wr(4'h8, 32'(i));
            rc("bank0", 4'h0, '1, (i < 4) ? e0[i] : 32'h0);
            if (i > 1)
                rc("bank4", 4'h4, '1, (i == 2) ? `DPR_TARGET_VAL :
                   (i == 3) ? `DPR_LINK_PID_VAL : 32'h0);
        end
        wr(4'h8, 32'h2);
        wr(4'h4, 32'hFFFF_FFFF);
        rc("target_ro", 4'h4, '1, `DPR_TARGET_VAL);
        rc("misaligned", 4'h5, '1, `DPR_TARGET_VAL);
        chk("addr_err", 32'h1, {31'h0, reg_addr_err_ff});
        ap_rdata = 32'hA5C3_5A3C;
        evp(6'h01);
        ap_rdata = 32'h5A3C_A5C3;
        wr(4'h8, 32'h3);
        rc("read_result_buffer", 4'hC, '1, 32'hA5C3_5A3C);
        strap('1, 1'b1, 7'h28);
        ptrs(32'hFFFF_F001, 32'h0000_00FF);
        strap('1, 1'b1, 7'h0C);
        ptrs(32'h0000_0001, 32'h0);
        strap('1, 1'b0, 7'h0C);
        ptrs(32'h0, 32'h0);
    endtask
    task automatic t_flags();
        int          cmap [5] = '{0, 4, 5, 7, 1};
        logic [31:0] ex = 32'hB2;
        strap(64'h0, 1'b0, 7'h20);
        wr(4'h4, 32'h5400_0001);
        evp(6'h3C);
        chk("pwr_req", 32'h7, {29'h0, req});
        abort_mapped = 1'b0;
        wr(4'h0, 32'h1F);
        rc("reserved_wr", 4'h4, 32'hB2, ex);
        chk("no_abort", 32'h0, 32'(n_ab));
        abort_mapped = 1'b1;
        wr(4'h0, 32'h1);
        rc("abort_keeps", 4'h4, 32'hF2, ex);
        evp(6'h02);
        rc("readok", 4'h4, 32'h40, 32'h40);
        for (int k = 1; k < 5; k++)
        begin
            wr(4'h0, 32'h1 << k);
            ex &= ~(32'h1 << cmap[k]);
            rc("flag_clr", 4'h4, 32'hB2, ex);
        end
        rc("pwr_ack", 4'h4, 32'hA800_0000, 32'hA800_0000);
    endtask
    task automatic t_abort();
        strap(64'h0, 1'b0, 7'h20);
        abort_mapped = 1'b1;
        wr(4'h4, 32'h0000_5000);
        go_busy = 1'b1;
        evp(6'h0);
        go_busy = 1'b0;
        n_ab = 0;
        n_st = 0;
        // the debugger sits through a long stall before it aborts
        repeat (8) @(posedge ref_clk);
        wr(4'h0, 32'h1);
        rc("wait_ans", 4'h4, 32'h00FF_F040, 32'h0);
        chk("abort_cnt", 32'h1, 32'(n_ab));
        chk("stop_cnt", 32'h1, 32'(n_st));
        chk("flushed", 32'h0, {31'h0, ap_busy});
        chk("not_stuck", 32'h0, {31'h0, ap_stuck_ff});
        evp(6'h02);
        cancel_ok = 1'b0;
        go_busy = 1'b1;
        evp(6'h0);
        go_busy = 1'b0;
        wr(4'h0, 32'h1);
        rc("wait_ans2", 4'h4, 32'h40, 32'h0);
        chk("stuck", 32'h1, {31'h0, ap_stuck_ff});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        t_map();
        t_flags();
        t_abort();
        complete_run();
    end
endmodule // tb
`default_nettype wire
